//--- common/ipb_pkg.sv
// Constants for the instruction prefetch and branch target cache block
package ipb_pkg;
	localparam int QUEUE_DEPTH = 8;
	localparam int BTC_ENTRIES = 15;
	localparam int BLOCK_WORDS = 8;
	localparam int ADDR_W      = 32;
	localparam int DATA_W      = 32;
	// Address bit that separates the two flash banks
	localparam int BANK_BIT    = 23;
	localparam logic        BOOT_SWAP_RST = 1'b0;
	localparam logic [31:0] WORD_STEP     = 32'h0000_0004;
	localparam logic [31:0] BLOCK_BYTES   = 32'h0000_0020;
	localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
endpackage : ipb_pkg

//--- logic/ipb_fetch.sv
// Instruction fetch path: prefetch queue, branch target cache, literal reads
`timescale 1ns/100ps
module ipb_fetch #(
	parameter int QD = ipb_pkg::QUEUE_DEPTH,
	parameter int NE = ipb_pkg::BTC_ENTRIES,
	parameter int BW = ipb_pkg::BLOCK_WORDS,
	parameter int AW = ipb_pkg::ADDR_W,
	parameter int DW = ipb_pkg::DATA_W
)(
	input  wire logic          CORE_CLK_I,
	input  wire logic          RESETN_I,
	input  wire logic          BOOT_BANK_I,
	input  wire logic          IFETCH_REQ_I,
	input  wire logic [AW-1:0] IFETCH_ADDR_I,
	input  wire logic          IFETCH_IRQVEC_I,
	output logic               IFETCH_RDY_O,
	output logic      [DW-1:0] IFETCH_DATA_O,
	input  wire logic          LIT_REQ_I,
	input  wire logic [AW-1:0] LIT_ADDR_I,
	output logic               LIT_RDY_O,
	output logic      [DW-1:0] LIT_DATA_O,
	output logic               FL_REQ_O,
	output logic               FL_BANK_O,
	output logic      [AW-1:0] FL_ADDR_O,
	input  wire logic          FL_ACK_I,
	input  wire logic [DW-1:0] FL_DATA_I
);
	localparam int QPW = $clog2(QD);
	localparam int CW  = $clog2(QD + 1);
	localparam int IW  = $clog2(NE);
	localparam int OW  = $clog2(BW);

	// Queue storage and pointers
	logic [DW-1:0]  q_mem_q [QD], q_mem_d [QD];
	logic [QPW-1:0] rd_q, rd_d;
	logic [QPW-1:0] wr_q, wr_d;
	logic [CW-1:0]  cnt_q, cnt_d;
	logic [AW-1:0]  ex_q, ex_d;
	logic [AW-1:0]  fa_q, fa_d;
	logic           seq_ok_q, seq_ok_d;
	// Flash access state
	logic           busy_q, busy_d;
	logic           lit_q, lit_d;
	logic           stale_q, stale_d;
	logic           bank_q, bank_d;
	logic [AW-1:0]  fl_addr_q, fl_addr_d;
	logic           lit_rdy_q, lit_rdy_d;
	logic [DW-1:0]  lit_data_q, lit_data_d;
	logic           boot_swap_q, boot_swap_d;
	logic           boot_seen_q, boot_seen_d;
	// Branch cache
	logic [AW-1:0]  tag_q [NE], tag_d [NE];
	logic           val_q [NE], val_d [NE];
	logic [IW-1:0]  age_q [NE], age_d [NE];
	logic [DW-1:0]  blk_q [NE][BW], blk_d [NE][BW];
	logic           cact_q, cact_d;
	logic [IW-1:0]  cidx_q, cidx_d;
	logic [OW-1:0]  coff_q, coff_d;
	logic           fact_q, fact_d;
	logic [IW-1:0]  fidx_q, fidx_d;
	logic [OW-1:0]  fcnt_q, fcnt_d;
	// Interrupt vector entry
	logic           vval_q, vval_d;
	logic [AW-1:0]  vtag_q, vtag_d;
	logic [DW-1:0]  vword_q, vword_d;
	logic           vfill_q, vfill_d;
	// Combinational helpers
	logic           hit, vhit, seq, nonseq, flush, pop, push;
	logic           free, inflight, lit_go, pf_go, touch, vfound;
	logic [IW-1:0]  hit_idx, victim, touch_idx;
	logic           rdy_c;
	logic [DW-1:0]  data_c;

	assign IFETCH_RDY_O  = rdy_c;
	assign IFETCH_DATA_O = data_c;
	assign LIT_RDY_O     = lit_rdy_q;
	assign LIT_DATA_O    = lit_data_q;
	assign FL_REQ_O      = busy_q;
	assign FL_ADDR_O     = fl_addr_q;
	assign FL_BANK_O     = bank_q;

	// Next state of the whole fetch path
	always_comb begin
		q_mem_d     = q_mem_q;
		rd_d        = rd_q;
		wr_d        = wr_q;
		cnt_d       = cnt_q;
		ex_d        = ex_q;
		fa_d        = fa_q;
		seq_ok_d    = seq_ok_q;
		busy_d      = busy_q;
		lit_d       = lit_q;
		stale_d     = stale_q;
		bank_d      = bank_q;
		fl_addr_d   = fl_addr_q;
		lit_rdy_d   = 1'b0;
		lit_data_d  = lit_data_q;
		boot_seen_d = 1'b1;
		tag_d       = tag_q;
		val_d       = val_q;
		age_d       = age_q;
		blk_d       = blk_q;
		cact_d      = cact_q;
		cidx_d      = cidx_q;
		coff_d      = coff_q;
		fact_d      = fact_q;
		fidx_d      = fidx_q;
		fcnt_d      = fcnt_q;
		vval_d      = vval_q;
		vtag_d      = vtag_q;
		vword_d     = vword_q;
		vfill_d     = vfill_q;
		rdy_c       = 1'b0;
		data_c      = q_mem_q[rd_q];
		flush       = 1'b0;
		pop         = 1'b0;
		touch       = 1'b0;
		// Boot bank strap caught on the first edge after release
		boot_swap_d = boot_seen_q ? boot_swap_q : BOOT_BANK_I;
		// Parallel tag match over all general entries
		hit     = 1'b0;
		hit_idx = '0;
		for (int i = 0; i < NE; i++) begin
			if (val_q[i] && tag_q[i] == IFETCH_ADDR_I) begin
				hit     = 1'b1;
				hit_idx = IW'(i);
			end
		end
		touch_idx = hit_idx;
		// Victim: first empty entry, else the oldest; a later empty one still wins
		vfound = 1'b0;
		victim = '0;
		for (int i = 0; i < NE; i++) begin
			if (!val_q[i] && !vfound) begin
				vfound = 1'b1;
				victim = IW'(i);
			end else if (!vfound && age_q[i] == IW'(NE - 1)) begin
				victim = IW'(i);
			end
		end
		seq    = IFETCH_REQ_I && seq_ok_q && IFETCH_ADDR_I == ex_q;
		nonseq = IFETCH_REQ_I && !seq;
		vhit   = IFETCH_IRQVEC_I && vval_q && vtag_q == IFETCH_ADDR_I;
		// Serve the core: cached block first, then the queue
		if (seq && cact_q) begin
			rdy_c  = 1'b1;
			data_c = blk_q[cidx_q][coff_q];
			ex_d   = ex_q + ipb_pkg::WORD_STEP;
			coff_d = coff_q + OW'(1);
			if (coff_q == OW'(BW - 1)) begin
				cact_d = 1'b0;
			end
		end else if (seq && cnt_q != '0) begin
			rdy_c = 1'b1;
			pop   = 1'b1;
			ex_d  = ex_q + ipb_pkg::WORD_STEP;
		end else if (nonseq) begin
			// Branch: queue contents no longer match the flow
			flush    = 1'b1;
			seq_ok_d = 1'b1;
			cact_d   = 1'b0;
			fact_d   = 1'b0;
			vfill_d  = 1'b0;
			if (vhit) begin
				rdy_c  = 1'b1;
				data_c = vword_q;
				ex_d   = IFETCH_ADDR_I + ipb_pkg::WORD_STEP;
				fa_d   = IFETCH_ADDR_I + ipb_pkg::WORD_STEP;
			end else if (hit) begin
				rdy_c  = 1'b1;
				data_c = blk_q[hit_idx][0];
				ex_d   = IFETCH_ADDR_I + ipb_pkg::WORD_STEP;
				cact_d = (BW > 1);
				cidx_d = hit_idx;
				coff_d = OW'(1);
				fa_d   = IFETCH_ADDR_I + ipb_pkg::BLOCK_BYTES;
				touch  = 1'b1;
			end else begin
				// Miss: core waits on the queue until the first word lands
				ex_d           = IFETCH_ADDR_I;
				fa_d           = IFETCH_ADDR_I;
				val_d[victim]  = 1'b0;
				tag_d[victim]  = IFETCH_ADDR_I;
				fact_d         = 1'b1;
				fidx_d         = victim;
				fcnt_d         = '0;
				touch          = 1'b1;
				touch_idx      = victim;
				if (IFETCH_IRQVEC_I) begin
					vfill_d = 1'b1;
					vval_d  = 1'b0;
					vtag_d  = IFETCH_ADDR_I;
				end
			end
		end
		// Age update keeps the ages a permutation of 0..NE-1
		if (touch) begin
			for (int i = 0; i < NE; i++) begin
				if (age_q[i] < age_q[touch_idx]) begin
					age_d[i] = age_q[i] + IW'(1);
				end
			end
			age_d[touch_idx] = '0;
		end
		// Completion of the flash access in flight
		push = busy_q && !lit_q && !stale_q && FL_ACK_I && !flush;
		if (busy_q && FL_ACK_I) begin
			busy_d  = 1'b0;
			stale_d = 1'b0;
			if (lit_q) begin
				lit_rdy_d  = 1'b1;
				lit_data_d = FL_DATA_I;
			end
		end
		// An old word still on its way is dropped when it arrives
		if (flush && busy_q && !lit_q && !FL_ACK_I) begin
			stale_d = 1'b1;
		end
		// Queue write, plus cache fill of the first words after a miss
		if (push) begin
			q_mem_d[wr_q] = FL_DATA_I;
			wr_d          = wr_q + QPW'(1);
			if (fact_q) begin
				blk_d[fidx_q][fcnt_q] = FL_DATA_I;
				fcnt_d                = fcnt_q + OW'(1);
				if (fcnt_q == OW'(BW - 1)) begin
					val_d[fidx_q] = 1'b1;
					fact_d        = 1'b0;
				end
			end
			if (vfill_q) begin
				vword_d = FL_DATA_I;
				vval_d  = 1'b1;
				vfill_d = 1'b0;
			end
		end
		if (pop) begin
			rd_d = rd_q + QPW'(1);
		end
		if (flush) begin
			rd_d  = '0;
			wr_d  = '0;
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + CW'(push) - CW'(pop);
		end
		// Issue: literal first, then prefetch while the queue has room
		free     = boot_seen_q && (!busy_q || FL_ACK_I);
		inflight = busy_q && !lit_q && !stale_q;
		lit_go   = free && LIT_REQ_I && !(busy_q && lit_q) && !lit_rdy_q;
		pf_go    = free && !lit_go && !flush && seq_ok_q
			&& (cnt_q + CW'(inflight) < CW'(QD));
		if (lit_go) begin
			busy_d    = 1'b1;
			lit_d     = 1'b1;
			fl_addr_d = LIT_ADDR_I;
		end else if (pf_go) begin
			busy_d    = 1'b1;
			lit_d     = 1'b0;
			fl_addr_d = fa_q;
			fa_d      = fa_q + ipb_pkg::WORD_STEP;
		end
		// Bank from the address, swapped when booting from the other bank
		bank_d = (busy_d && !busy_q) || (lit_go || pf_go)
			? fl_addr_d[ipb_pkg::BANK_BIT] ^ boot_swap_q : bank_q;
	end

	// Control registers
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rd_q        <= '0;
			wr_q        <= '0;
			cnt_q       <= '0;
			ex_q        <= ipb_pkg::ADDR_RST;
			fa_q        <= ipb_pkg::ADDR_RST;
			seq_ok_q    <= 1'b0;
			busy_q      <= 1'b0;
			lit_q       <= 1'b0;
			stale_q     <= 1'b0;
			bank_q      <= 1'b0;
			fl_addr_q   <= ipb_pkg::ADDR_RST;
			lit_rdy_q   <= 1'b0;
			lit_data_q  <= '0;
			boot_swap_q <= ipb_pkg::BOOT_SWAP_RST;
			boot_seen_q <= 1'b0;
			cact_q      <= 1'b0;
			cidx_q      <= '0;
			coff_q      <= '0;
			fact_q      <= 1'b0;
			fidx_q      <= '0;
			fcnt_q      <= '0;
			vval_q      <= 1'b0;
			vtag_q      <= ipb_pkg::ADDR_RST;
			vword_q     <= '0;
			vfill_q     <= 1'b0;
			for (int i = 0; i < NE; i++) begin
				tag_q[i] <= ipb_pkg::ADDR_RST;
				val_q[i] <= 1'b0;
				age_q[i] <= IW'(i);
			end
		end else begin
			rd_q        <= rd_d;
			wr_q        <= wr_d;
			cnt_q       <= cnt_d;
			ex_q        <= ex_d;
			fa_q        <= fa_d;
			seq_ok_q    <= seq_ok_d;
			busy_q      <= busy_d;
			lit_q       <= lit_d;
			stale_q     <= stale_d;
			bank_q      <= bank_d;
			fl_addr_q   <= fl_addr_d;
			lit_rdy_q   <= lit_rdy_d;
			lit_data_q  <= lit_data_d;
			boot_swap_q <= boot_swap_d;
			boot_seen_q <= boot_seen_d;
			cact_q      <= cact_d;
			cidx_q      <= cidx_d;
			coff_q      <= coff_d;
			fact_q      <= fact_d;
			fidx_q      <= fidx_d;
			fcnt_q      <= fcnt_d;
			vval_q      <= vval_d;
			vtag_q      <= vtag_d;
			vword_q     <= vword_d;
			vfill_q     <= vfill_d;
			tag_q       <= tag_d;
			val_q       <= val_d;
			age_q       <= age_d;
		end
	end

	// Word storage; no reset since valid bits and the queue count guard every read
	always_ff @(posedge CORE_CLK_I) begin
		q_mem_q <= q_mem_d;
		blk_q   <= blk_d;
	end
endmodule : ipb_fetch

//--- verif/ipb_fetch_asserts.sv
// Concurrent checks on the fetch block ports
`timescale 1ns/100ps
module ipb_fetch_asserts (
	input wire logic        CORE_CLK_I,
	input wire logic        RESETN_I,
	input wire logic        BOOT_BANK_I,
	input wire logic        IFETCH_REQ_I,
	input wire logic [31:0] IFETCH_ADDR_I,
	input wire logic        IFETCH_RDY_O,
	input wire logic        LIT_REQ_I,
	input wire logic        LIT_RDY_O,
	input wire logic        FL_REQ_O,
	input wire logic        FL_BANK_O,
	input wire logic [31:0] FL_ADDR_O,
	input wire logic        FL_ACK_I
);
	logic       first_q;
	logic [3:0] acks_q;
	// First word after reset is a miss; acks counted since last delivery
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			first_q <= 1'b1;
			acks_q  <= 4'h0;
		end else begin
			if (IFETCH_RDY_O) first_q <= 1'b0;
			if (IFETCH_RDY_O || LIT_RDY_O) acks_q <= 4'h0;
			else if (FL_ACK_I && acks_q != 4'hF) acks_q <= acks_q + 4'h1;
		end
	end
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	sequence s_first_req;
		first_q && $rose(IFETCH_REQ_I);
	endsequence
	sequence s_stall;
		!IFETCH_RDY_O [*3];
	endsequence
	a_flash_req_hold: assert property (
		FL_REQ_O && !FL_ACK_I |=> FL_REQ_O && $stable(FL_ADDR_O) && $stable(FL_BANK_O))
		else $error("flash request dropped or changed before ack");
	a_bank_select: assert property (
		FL_REQ_O |-> FL_BANK_O == (FL_ADDR_O[23] ^ BOOT_BANK_I))
		else $error("flash bank select wrong");
	a_word_aligned: assert property (FL_REQ_O |-> FL_ADDR_O[1:0] == 2'h0)
		else $error("flash address not word aligned");
	a_first_miss: assert property (s_first_req |-> s_stall)
		else $error("first fetch not stalled");
	a_miss_refetch: assert property (
		s_first_req |-> ##2 (FL_REQ_O && FL_ADDR_O == $past(IFETCH_ADDR_I, 2)))
		else $error("miss did not restart flash at target");
	a_lit_after_ack: assert property (LIT_RDY_O |-> $past(FL_ACK_I))
		else $error("literal ready without flash ack");
	a_lit_latency: assert property ($rose(LIT_REQ_I) |-> ##[2:60] LIT_RDY_O)
		else $error("literal not served in time");
	a_ahead_limit: assert property (acks_q <= 4'h9)
		else $error("prefetch ran too far ahead");
endmodule : ipb_fetch_asserts
bind ipb_fetch ipb_fetch_asserts ipb_fetch_asserts_inst (.CORE_CLK_I, .RESETN_I,
	.BOOT_BANK_I, .IFETCH_REQ_I, .IFETCH_ADDR_I, .IFETCH_RDY_O, .LIT_REQ_I,
	.LIT_RDY_O, .FL_REQ_O, .FL_BANK_O, .FL_ADDR_O, .FL_ACK_I);

//--- verif/ipb_flash_model.sv
// Behavioural burst flash answering one word per access
`timescale 1ns/100ps
module ipb_flash_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        slow_i,
	input  wire logic        req_i,
	input  wire logic        bank_i,
	input  wire logic [31:0] addr_i,
	output logic             ack_o,
	output logic      [31:0] data_o
);
	logic [1:0] wait_q;
	// Data toggles outside ack so a stale word never looks valid
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o  <= 1'b0;
			wait_q <= 2'h0;
			data_o <= 32'h0000_0000;
		end else if (ack_o || !req_i) begin
			ack_o  <= 1'b0;
			wait_q <= slow_i ? 2'($urandom % 4) : 2'h0;
			data_o <= ~data_o;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
			data_o <= ~data_o;
		end else begin
			ack_o  <= 1'b1;
			data_o <= addr_i ^ {bank_i, 31'h0} ^ 32'hA5A5_0000;
		end
	end
endmodule : ipb_flash_model

//--- verif/tb_instruction_prefetch_branch_cache.sv
// Self-checking bench for the fetch block with a flash model
`timescale 1ns/100ps
module tb_instruction_prefetch_branch_cache;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        boot = 1'b0;
	logic        slow = 1'b0;
	logic        req = 1'b0;
	logic        irqvec = 1'b0;
	logic        lit_req = 1'b0;
	logic [31:0] addr = 32'h0000_0000;
	logic [31:0] lit_addr = 32'h0000_0000;
	logic        rdy, lit_rdy, fl_req, fl_bank, fl_ack;
	logic [31:0] data, lit_data, fl_addr, fl_data, got;
	logic [31:0] t [16];
	int          mismatches = 0;
	int          check_count = 0;
	int          lat;
	always #4 clk = ~clk;
	ipb_fetch ipb_fetch_inst (.CORE_CLK_I(clk), .RESETN_I(rst_n), .BOOT_BANK_I(boot),
		.IFETCH_REQ_I(req), .IFETCH_ADDR_I(addr), .IFETCH_IRQVEC_I(irqvec),
		.IFETCH_RDY_O(rdy), .IFETCH_DATA_O(data), .LIT_REQ_I(lit_req),
		.LIT_ADDR_I(lit_addr), .LIT_RDY_O(lit_rdy), .LIT_DATA_O(lit_data),
		.FL_REQ_O(fl_req), .FL_BANK_O(fl_bank), .FL_ADDR_O(fl_addr),
		.FL_ACK_I(fl_ack), .FL_DATA_I(fl_data));
	ipb_flash_model ipb_flash_model_inst (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
		.req_i(fl_req), .bank_i(fl_bank), .addr_i(fl_addr), .ack_o(fl_ack), .data_o(fl_data));
	// Word the flash model returns, bank swapped by the strap
	function automatic logic [31:0] fl_word(input logic [31:0] a);
		return a ^ {a[23] ^ boot, 31'h0} ^ 32'hA5A5_0000;
	endfunction : fl_word
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
		check_count++;
		if (act !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, act);
		end
	endtask : check
	task automatic wrap_up;
		if (mismatches == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic do_reset(input logic b);
		@(negedge clk);
		req = 1'b0;
		lit_req = 1'b0;
		rst_n = 1'b0;
		boot = b;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
	endtask : do_reset
	// Request held from a falling edge until ready; lat counts waits
	task automatic fetch(input logic [31:0] a, input logic iv);
		@(negedge clk);
		req = 1'b1;
		addr = a;
		irqvec = iv;
		lat = 0;
		#1;
		while (rdy !== 1'b1 && lat < 50) begin
			@(negedge clk);
			#1;
			lat++;
		end
		check("ifetch ready", 32'h0000_0001, {31'h0000_0000, rdy});
		got = data;
	endtask : fetch
	// Mode 0 expects a miss, 1 a hit, 2 plain sequential
	task automatic run(input logic [31:0] a, input int n, input logic iv, input int mode);
		for (int i = 0; i < n; i++) begin
			fetch(a + 32'(4 * i), iv && i == 0);
			check("ifetch data", fl_word(a + 32'(4 * i)), got);
			if (mode == 1 && i < (iv ? 1 : 8))
				check("hit wait", 32'h0000_0000, 32'(lat));
			if (mode == 0 && i == 0)
				check("miss stall", 32'h0000_0001, 32'(lat >= 4));
		end
	endtask : run
	task automatic idle(input int n);
		@(negedge clk);
		req = 1'b0;
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic lit(input logic [31:0] a);
		@(negedge clk);
		lit_req = 1'b1;
		lit_addr = a;
		lat = 0;
		while (lit_rdy !== 1'b1 && lat < 50) begin
			@(negedge clk);
			lat++;
		end
		check("literal ready", 32'h0000_0001, {31'h0000_0000, lit_rdy});
		check("literal data", fl_word(a), lit_data);
		// Request stays up through the edge that samples ready high
		@(negedge clk);
		lit_req = 1'b0;
	endtask : lit
	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
	initial begin
		void'($urandom(18));
		do_reset(1'b0);
		fetch(32'h0000_0100, 1'b0);
		check("first miss wait", 32'h0000_0004, 32'(lat));
		check("first word", fl_word(32'h0000_0100), got);
		slow = 1'b1;
		run(32'h0000_0104, 11, 1'b0, 2);
		run(32'h0080_0200, 10, 1'b0, 0);
		run(32'h0000_0100, 12, 1'b0, 1);
		// Queue fills while the core idles; a literal must keep it
		run(32'h0000_0400, 8, 1'b0, 0);
		idle(20);
		lit(32'h0000_8000 + 32'($urandom % 256) * 32'h0000_0004);
		fetch(32'h0000_0420, 1'b0);
		check("post-literal wait", 32'h0000_0000, 32'(lat));
		run(32'h0000_0018, 2, 1'b1, 0);
		run(32'h0000_0600, 9, 1'b0, 0);
		run(32'h0000_0018, 2, 1'b1, 1);
		// Sixteen fresh targets push the oldest out
		for (int i = 0; i < 16; i++) begin
			t[i] = 32'h0001_0000 + 32'(i * 256 + ($urandom % 4) * 32);
			run(t[i], 8, 1'b0, 0);
		end
		run(t[0], 8, 1'b0, 0);
		run(t[15], 8, 1'b0, 1);
		do_reset(1'b1);
		run(32'h0080_0040, 9, 1'b0, 0);
		idle(4);
		wrap_up();
	end
endmodule : tb_instruction_prefetch_branch_cache
